// *** tb/load_store_stack_exec_tb_top.sv ***
// Purpose: self-checking bench for single and stack transfers
// Assumes: registers and memory start at zero
// Notes: beats and completions are checked from queues of notes
`timescale 1ns/1ns
`include "lsse_params.svh"
module load_store_stack_exec_tb_top;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_cmd_valid = 1'b0;
	lsse_pkg::lsse_cmd_t i_cmd = '0;
	logic i_rf_we = 1'b0;
	logic [3:0] i_rf_idx = 4'h0;
	logic [31:0] i_rf_data = 32'h0;
	logic i_flags_we = 1'b0;
	logic [3:0] i_flags = 4'h0;
	logic [3:0] i_dbg_idx = 4'h0;
	logic [1:0] i_wait = 2'h0;
	logic i_mem_ack;
	logic [31:0] i_mem_rdata;
	lsse_pkg::lsse_mem_t o_mem;
	logic o_busy, o_done, o_fault, o_branch;
	logic [3:0] o_flags;
	logic [31:0] o_dbg_data;
	integer seed = 32'hd68f;
	int errors = 0;
	int total_checks = 0;
	logic [31:0] rf [16];
	logic [31:0] shadow [64];
	logic [69:0] beat_q [$];
	logic [1:0] done_q [$];
	logic [3:0] fl;
	lsse_pkg::lsse_cmd_t bad [6];
	always #50 i_clk = ~i_clk;
	lsse_exec u_lsse_exec (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
		.i_rf_we(i_rf_we), .i_rf_idx(i_rf_idx), .i_rf_data(i_rf_data), .i_flags_we(i_flags_we),
		.i_flags(i_flags), .i_dbg_idx(i_dbg_idx), .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata),
		.o_mem(o_mem), .o_busy(o_busy), .o_done(o_done), .o_fault(o_fault), .o_branch(o_branch),
		.o_flags(o_flags), .o_dbg_data(o_dbg_data));
	lsse_mem_model u_lsse_mem_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_mem(o_mem), .i_wait(i_wait),
		.o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
	// compare and count
	task automatic chk(logic [69:0] got, logic [69:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks=%0d mismatches=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	function automatic logic [69:0] bv(logic we, logic [31:0] a, logic [31:0] d, logic [3:0] be);
		bv = {we, a >= `LSSE_PERIPH_LO && a <= `LSSE_PERIPH_HI, a, be, we ? d : 32'h0};
	endfunction
	function automatic lsse_pkg::lsse_cmd_t mk(lsse_pkg::lsse_op_t op, lsse_pkg::lsse_size_t sz, logic sg,
		logic [3:0] rb, logic [1:0] shf, logic [15:0] l);
		mk = {op, sz, sg, 4'h3, rb, 4'h2, shf, l};
	endfunction
	// watcher: each beat and each completion takes the oldest note
	always @(posedge i_clk)
	begin
		if (i_rst_n && o_mem.req && i_mem_ack)
			chk({o_mem.we, o_mem.periph, o_mem.addr, o_mem.be, o_mem.we ? o_mem.wdata : 32'h0},
				beat_q.size() ? beat_q.pop_front() : 'x);
		if (i_rst_n && o_mem.req && i_mem_ack)
			chk(o_busy, 1'b1);
		if (i_rst_n && o_done)
			chk({o_fault, o_branch}, done_q.size() ? done_q.pop_front() : 'x);
		if (i_rst_n && o_done)
			chk(o_busy, 1'b0);
	end
	task automatic wr(logic [3:0] i, logic [31:0] v);
		@(posedge i_clk);
		i_rf_we <= 1'b1;
		i_rf_idx <= i;
		i_rf_data <= v;
		rf[i] = v;
		@(posedge i_clk);
		i_rf_we <= 1'b0;
	endtask
	task automatic rd(logic [3:0] i);
		@(posedge i_clk);
		i_dbg_idx <= i;
		repeat (2) @(posedge i_clk);
		#1;
		chk(o_dbg_data, rf[i]);
	endtask
	task automatic cmd(lsse_pkg::lsse_cmd_t c);
		int t;
		t = 0;
		@(posedge i_clk);
		i_cmd_valid <= 1'b1;
		i_cmd <= c;
		i_wait <= 2'($random(seed));
		@(posedge i_clk);
		i_cmd_valid <= 1'b0;
		#1;
		while (o_done !== 1'b1 && t < 200)
		begin
			@(posedge i_clk);
			#1;
			t++;
		end
		chk(t < 200, 1'b1);
	endtask
	// single transfer through base plus shifted offset
	task automatic ls(logic st, lsse_pkg::lsse_size_t sz, logic sg, logic [31:0] a);
		logic [31:0] off, w, d, v;
		logic [3:0] be;
		logic [1:0] shf;
		shf = 2'($random(seed));
		off = $random(seed) & 32'hFF;
		wr(4'h1, a - (off << shf));
		wr(4'h2, off);
		w = shadow[a[7:2]];
		v = w >> {a[1:0], 3'h0};
		be = 4'hF;
		d = rf[3];
		if (sz == lsse_pkg::LSSE_SZ_BYTE)
		begin
			be = 4'h1 << a[1:0];
			d = {4{rf[3][7:0]}};
			v = {sg ? {24{v[7]}} : 24'h0, v[7:0]};
		end
		if (sz == lsse_pkg::LSSE_SZ_HALF)
		begin
			be = a[1] ? 4'hC : 4'h3;
			d = {2{rf[3][15:0]}};
			v = w >> {a[1], 4'h0};
			v = {sg ? {16{v[15]}} : 16'h0, v[15:0]};
		end
		beat_q.push_back(bv(st, a, d, be));
		done_q.push_back(2'b00);
		for (int k = 0; k < 4; k++)
			if (st && be[k])
				shadow[a[7:2]][8*k+:8] = d[8*k+:8];
		cmd(mk(st ? lsse_pkg::LSSE_OP_STORE_REGISTER : lsse_pkg::LSSE_OP_LOAD_REGISTER, sz, sg, 4'h1, shf, 16'h0));
		if (!st)
			rf[3] = v;
		rd(4'h3);
	endtask
	// stack store or load of list l, ef is the expected fault and branch
	task automatic stk(logic p, logic [15:0] l, logic [1:0] ef);
		logic [31:0] a, v;
		a = p ? rf[13] : rf[13] - 32'($countones(l) * 4);
		for (int k = 0; k < 16; k++)
			if (l[k])
			begin
				v = shadow[a[7:2]];
				beat_q.push_back(bv(!p, a, rf[k], 4'hF));
				if (p)
					rf[k] = (k == 15) ? v & `LSSE_BRANCH_MASK : v;
				else
					shadow[a[7:2]] = rf[k];
				a = a + 32'h4;
			end
		rf[13] = p ? a : rf[13] - 32'($countones(l) * 4);
		done_q.push_back(ef);
		cmd(mk(p ? lsse_pkg::LSSE_OP_LOAD_MULTIPLE_INCREMENT_AFTER : lsse_pkg::LSSE_OP_STORE_MULTIPLE_DECREMENT_BEFORE,
			lsse_pkg::LSSE_SZ_WORD, 1'b0, 4'hD, 2'h0, l));
		for (int k = 0; k < 16; k++)
			if (l[k] || k == 13)
				rd(4'(k));
		chk(o_flags, fl);
	endtask
	// main sequence
	initial
	begin
		for (int k = 0; k < 64; k++)
			shadow[k] = 32'h0;
		for (int k = 0; k < 16; k++)
			rf[k] = 32'h0;
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		fl = 4'($random(seed));
		@(posedge i_clk);
		i_flags_we <= 1'b1;
		i_flags <= fl;
		@(posedge i_clk);
		i_flags_we <= 1'b0;
		wr(4'h3, $random(seed));
		ls(1'b1, lsse_pkg::LSSE_SZ_WORD, 1'b0, 32'h20000040);
		for (int k = 0; k < 8; k++)
			ls(1'b0, lsse_pkg::LSSE_SZ_BYTE, k[2], 32'h20000040 + k[1:0]);
		for (int k = 0; k < 4; k++)
			ls(1'b0, lsse_pkg::LSSE_SZ_HALF, k[0], 32'h20000040 + {k[1], 1'b0});
		wr(4'h3, $random(seed));
		ls(1'b1, lsse_pkg::LSSE_SZ_BYTE, 1'b0, 32'h20000041);
		ls(1'b1, lsse_pkg::LSSE_SZ_HALF, 1'b0, 32'h20000042);
		ls(1'b0, lsse_pkg::LSSE_SZ_WORD, 1'b0, 32'h20000040);
		ls(1'b1, lsse_pkg::LSSE_SZ_HALF, 1'b0, 32'hE000E012);
		ls(1'b0, lsse_pkg::LSSE_SZ_WORD, 1'b0, 32'hE000E010);
		$display("test single transfers done");
		bad[0] = mk(lsse_pkg::LSSE_OP_STORE_REGISTER, lsse_pkg::LSSE_SZ_BYTE, 1'b1, 4'h1, 2'h0, 16'h0);
		bad[1] = mk(lsse_pkg::LSSE_OP_LOAD_REGISTER, lsse_pkg::LSSE_SZ_WORD, 1'b0, 4'hF, 2'h0, 16'h0);
		bad[2] = mk(lsse_pkg::LSSE_OP_STORE_MULTIPLE_DECREMENT_BEFORE, lsse_pkg::LSSE_SZ_WORD, 1'b0, 4'hD, 2'h0, 16'h0);
		bad[3] = mk(lsse_pkg::LSSE_OP_STORE_MULTIPLE_DECREMENT_BEFORE, lsse_pkg::LSSE_SZ_WORD, 1'b0, 4'hD, 2'h0, 16'h2001);
		bad[4] = mk(lsse_pkg::LSSE_OP_STORE_MULTIPLE_DECREMENT_BEFORE, lsse_pkg::LSSE_SZ_WORD, 1'b0, 4'hD, 2'h0, 16'h8001);
		bad[5] = mk(lsse_pkg::LSSE_OP_LOAD_MULTIPLE_INCREMENT_AFTER, lsse_pkg::LSSE_SZ_WORD, 1'b0, 4'hD, 2'h0, 16'hC001);
		for (int k = 0; k < 6; k++)
		begin
			done_q.push_back(2'b10);
			cmd(bad[k]);
		end
		rd(4'h3);
		$display("test refusals done");
		wr(4'hD, 32'h20000100);
		for (int j = 0; j < 3; j++)
		begin
			for (int k = 0; k < 15; k++)
				if (k != 13)
					wr(4'(k), $random(seed));
			// new flags while idle; the stack ops that follow must keep them
			@(posedge i_clk);
			i_flags_we <= 1'b1;
			i_flags <= rf[0][3:0];
			fl = rf[0][3:0];
			@(posedge i_clk);
			i_flags_we <= 1'b0;
			stk(1'b0, (16'($random(seed)) & 16'h5FFF) | 16'h0001, 2'b00);
			for (int k = 0; k < 15; k++)
				if (k != 13)
					wr(4'(k), $random(seed));
			stk(1'b1, (16'($random(seed)) & 16'h5FFF) | 16'h0001, 2'b00);
		end
		stk(1'b0, 16'h00F1, 2'b00);
		wr(4'h5, $random(seed) | 32'h1);
		stk(1'b0, 16'h0020, 2'b00);
		stk(1'b1, 16'h8000, 2'b01);
		wr(4'h5, $random(seed) & `LSSE_BRANCH_MASK);
		stk(1'b0, 16'h0020, 2'b00);
		stk(1'b1, 16'h8000, 2'b11);
		$display("test stack transfers done");
		end_of_test;
	end
	// watchdog
	initial
	begin
		repeat (20000) @(posedge i_clk);
		errors++;
		end_of_test;
	end
endmodule

// *** tb/lsse_mem_model.sv ***
// Purpose: behavioural memory on the far side of the data bus
// Assumes: one beat per request, ack lasts one cycle
// Notes: i_wait adds 0..3 idle cycles before each ack
`timescale 1ns/1ns
module lsse_mem_model
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// request and pacing
	input wire lsse_pkg::lsse_mem_t i_mem,
	input wire logic [1:0] i_wait,
	// answer
	output logic o_ack,
	output logic [31:0] o_rdata
);
	logic [31:0] mem [64];
	logic [1:0] cnt_q;
	initial
	begin
		for (int k = 0; k < 64; k++)
			mem[k] = 32'h0;
	end
	// ack after the wait, read data garbled while no ack stands
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_ack <= 1'b0;
			o_rdata <= 32'h0;
			cnt_q <= 2'h0;
		end
		else
		begin
			o_ack <= 1'b0;
			o_rdata <= ~o_rdata;
			if (i_mem.req && !o_ack)
			begin
				if (cnt_q == i_wait)
				begin
					o_ack <= 1'b1;
					o_rdata <= mem[i_mem.addr[7:2]];
					cnt_q <= 2'h0;
				end
				else
					cnt_q <= cnt_q + 2'h1;
			end
			// byte k of a word sits at address offset k
			if (i_mem.req && o_ack && i_mem.we)
				for (int k = 0; k < 4; k++)
					if (i_mem.be[k])
						mem[i_mem.addr[7:2]][8*k+:8] <= i_mem.wdata[8*k+:8];
		end
	end
endmodule

// *** verilog/lsse_addr_gen.sv ***
// Purpose: address arithmetic for single and stack transfers
// Assumes: count is the number of registers in the list
// Notes: purely combinational
`timescale 1ns/1ns
`include "lsse_params.svh"
module lsse_addr_gen
(
	// operands
	input wire logic [31:0] i_base,
	input wire logic [31:0] i_offset,
	input wire logic [1:0] i_shift,
	input wire logic [31:0] i_stack,
	input wire logic [4:0] i_count,
	// results
	output logic [31:0] o_single_addr,
	output logic [31:0] o_push_start,
	output logic [31:0] o_pop_final
);
	logic [31:0] span;
	// base plus offset shifted left by 0 to 3, stack span in bytes
	always_comb
	begin
		o_single_addr = i_base + (i_offset << i_shift);
		span = {25'h0, i_count, 2'h0};
		o_push_start = i_stack - span;
		o_pop_final = i_stack + span;
	end
endmodule

// *** verilog/lsse_exec.sv ***
// Purpose: executes register-offset loads/stores and stack store/load
// Assumes: decoded commands, one memory beat per word, ack with read data
// Notes:
// Summary of operation
// - data accesses use little-endian byte lanes
// - peripheral bus also little-endian
// - address is base plus shifted offset
// - sizes byte, halfword, word; word default
// - unsigned loads zero-extend to 32 bits
// - signed loads sign-extend; signed stores refused
// - stack ops decrement-before/increment-after, write back
// - store: highest register at highest address
// - load: lowest register from lowest address
// - loaded program counter bit0 cleared, halfword branch; bit0 clear in the loaded word faults
// - stack ops leave condition flags unchanged
`timescale 1ns/1ns
`include "lsse_params.svh"
module lsse_exec
#(
	parameter int NREG = 16,
	parameter int XLEN = 32
)
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// decoded command
	input wire logic i_cmd_valid,
	input wire lsse_pkg::lsse_cmd_t i_cmd,
	// register preload and flag update while idle, register read-back select
	input wire logic i_rf_we,
	input wire logic [3:0] i_rf_idx,
	input wire logic [31:0] i_rf_data,
	input wire logic i_flags_we,
	input wire logic [3:0] i_flags,
	input wire logic [3:0] i_dbg_idx,
	// memory answer
	input wire logic i_mem_ack,
	input wire logic [31:0] i_mem_rdata,
	// memory request
	output lsse_pkg::lsse_mem_t o_mem,
	// status
	output logic o_busy,
	output logic o_done,
	output logic o_fault,
	output logic o_branch,
	output logic [3:0] o_flags,
	output logic [31:0] o_dbg_data
);
	if (NREG != 16 || XLEN != 32)
		$error("lsse_exec serves only sixteen 32-bit registers");

	lsse_pkg::lsse_exec_state_t s_q;
	lsse_pkg::lsse_exec_state_t s_d;
	logic idle;
	logic [31:0] single_addr;
	logic [31:0] push_start;
	logic [31:0] pop_final;
	logic [1:0] lane_addr;
	lsse_pkg::lsse_size_t lane_size;
	logic lane_sign;
	logic [31:0] lane_wdata;
	logic [3:0] lane_be;
	logic [31:0] lane_value;

	// number of registers in a list
	function automatic logic [4:0] lsse_count(input logic [15:0] l);
		logic [4:0] n;
		n = 5'h0;
		for (int i = 0; i < 16; i++)
			n = n + {4'h0, l[i]};
		return n;
	endfunction

	// lowest register number in a list
	function automatic logic [3:0] lsse_lowest(input logic [15:0] l);
		logic [3:0] k;
		k = 4'h0;
		for (int i = 15; i >= 0; i--)
			if (l[i])
				k = 4'(i);
		return k;
	endfunction

	// peripheral bus region of the address space
	function automatic logic lsse_in_periph(input logic [31:0] a);
		return (a >= `LSSE_PERIPH_LO) && (a <= `LSSE_PERIPH_HI);
	endfunction

	// operands come from the command while idle, from the held command later
	assign idle = (s_q.state == lsse_pkg::LSSE_ST_IDLE);
	assign lane_addr = idle ? single_addr[1:0] : s_q.mem.addr[1:0];
	assign lane_size = idle ? i_cmd.size : s_q.cmd.size;
	assign lane_sign = idle ? i_cmd.sign : s_q.cmd.sign;

	lsse_addr_gen u_addr
	(
		.i_base(s_q.regs[i_cmd.base_register]),
		.i_offset(s_q.regs[i_cmd.offset_register]),
		.i_shift(i_cmd.left_shift_option),
		.i_stack(s_q.regs[`LSSE_STACK_IDX]),
		.i_count(lsse_count(i_cmd.reg_list)),
		.o_single_addr(single_addr),
		.o_push_start(push_start),
		.o_pop_final(pop_final)
	);

	lsse_lane u_lane
	(
		.i_addr_lo(lane_addr),
		.i_size(lane_size),
		.i_sign(lane_sign),
		.i_store_data(s_q.regs[i_cmd.transfer_register]),
		.i_load_data(i_mem_rdata),
		.o_wdata(lane_wdata),
		.o_be(lane_be),
		.o_value(lane_value)
	);

	// next-state logic: command acceptance, single beat, stack beats
	always_comb
	begin
		logic is_single;
		logic is_push;
		logic bad;
		logic [3:0] idx;
		logic [15:0] rest;
		logic [31:0] next_addr;
		is_single = 1'b0;
		is_push = 1'b0;
		bad = 1'b0;
		idx = 4'h0;
		rest = 16'h0000;
		next_addr = `LSSE_RST_WORD;
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.fault = 1'b0;
		s_d.branch = 1'b0;
		s_d.dbg_data = s_q.regs[i_dbg_idx];
		case (s_q.state)
			lsse_pkg::LSSE_ST_IDLE:
			begin
				if (i_rf_we)
					s_d.regs[i_rf_idx] = i_rf_data;
				if (i_flags_we)
					s_d.flags = i_flags;
				is_single = (i_cmd.op == lsse_pkg::LSSE_OP_LOAD_REGISTER) ||
					(i_cmd.op == lsse_pkg::LSSE_OP_STORE_REGISTER);
				is_push = (i_cmd.op == lsse_pkg::LSSE_OP_STORE_MULTIPLE_DECREMENT_BEFORE);
				if (is_single)
					bad = (i_cmd.base_register == `LSSE_PROG_IDX) ||
						(i_cmd.op == lsse_pkg::LSSE_OP_STORE_REGISTER && i_cmd.sign);
				else
					bad = (i_cmd.reg_list == 16'h0000) || i_cmd.reg_list[`LSSE_STACK_IDX] ||
						(is_push && i_cmd.reg_list[`LSSE_PROG_IDX]) ||
						(!is_push && i_cmd.reg_list[`LSSE_PROG_IDX] && i_cmd.reg_list[`LSSE_LINK_IDX]);
				if (i_cmd_valid && bad)
				begin
					s_d.fault = 1'b1;
					s_d.done = 1'b1;
				end
				else if (i_cmd_valid && is_single)
				begin
					s_d.cmd = i_cmd;
					s_d.state = lsse_pkg::LSSE_ST_SINGLE;
					s_d.busy = 1'b1;
					s_d.mem.req = 1'b1;
					s_d.mem.we = (i_cmd.op == lsse_pkg::LSSE_OP_STORE_REGISTER);
					s_d.mem.addr = single_addr;
					s_d.mem.periph = lsse_in_periph(single_addr);
					s_d.mem.wdata = lane_wdata;
					s_d.mem.be = lane_be;
				end
				else if (i_cmd_valid)
				begin
					idx = lsse_lowest(i_cmd.reg_list);
					next_addr = is_push ? push_start : s_q.regs[`LSSE_STACK_IDX];
					s_d.cmd = i_cmd;
					s_d.list = i_cmd.reg_list;
					s_d.stack_new = is_push ? push_start : pop_final;
					s_d.state = lsse_pkg::LSSE_ST_MULTI;
					s_d.busy = 1'b1;
					s_d.mem.req = 1'b1;
					s_d.mem.we = is_push;
					s_d.mem.addr = next_addr;
					s_d.mem.periph = lsse_in_periph(next_addr);
					s_d.mem.wdata = s_q.regs[idx];
					s_d.mem.be = `LSSE_BE_WORD;
				end
			end
			lsse_pkg::LSSE_ST_SINGLE:
			begin
				if (i_mem_ack)
				begin
					if (!s_q.mem.we)
						s_d.regs[s_q.cmd.transfer_register] = lane_value;
					s_d.mem.req = 1'b0;
					s_d.busy = 1'b0;
					s_d.done = 1'b1;
					s_d.state = lsse_pkg::LSSE_ST_IDLE;
				end
			end
			lsse_pkg::LSSE_ST_MULTI:
			begin
				if (i_mem_ack)
				begin
					idx = lsse_lowest(s_q.list);
					rest = s_q.list;
					rest[idx] = 1'b0;
					if (!s_q.mem.we && idx == `LSSE_PROG_IDX)
					begin
						s_d.regs[idx] = i_mem_rdata & `LSSE_BRANCH_MASK;
						s_d.branch = 1'b1;
						s_d.fault = !i_mem_rdata[0];
					end
					else if (!s_q.mem.we)
						s_d.regs[idx] = i_mem_rdata;
					s_d.list = rest;
					next_addr = s_q.mem.addr + `LSSE_WORD_STEP;
					if (rest == 16'h0000)
					begin
						s_d.regs[`LSSE_STACK_IDX] = s_q.stack_new;
						s_d.mem.req = 1'b0;
						s_d.busy = 1'b0;
						s_d.done = 1'b1;
						s_d.state = lsse_pkg::LSSE_ST_IDLE;
					end
					else
					begin
						s_d.mem.addr = next_addr;
						s_d.mem.periph = lsse_in_periph(next_addr);
						s_d.mem.wdata = s_q.regs[lsse_lowest(rest)];
					end
				end
			end
			default:
				s_d.state = lsse_pkg::LSSE_ST_IDLE;
		endcase
	end

	// state register; flags change only by the idle update port
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign o_mem = s_q.mem;
	assign o_busy = s_q.busy;
	assign o_done = s_q.done;
	assign o_fault = s_q.fault;
	assign o_branch = s_q.branch;
	assign o_flags = s_q.flags;
	assign o_dbg_data = s_q.dbg_data;

	// checks on lane steering, addressing and stack order
	chk_byte_lane: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_mem.req && s_q.cmd.size == lsse_pkg::LSSE_SZ_BYTE && s_q.state == lsse_pkg::LSSE_ST_SINGLE
		|-> o_mem.be == (`LSSE_BE_BYTE0 << o_mem.addr[1:0]))
		else $error("byte lane not little-endian");
	chk_periph_lane: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_mem.req && o_mem.periph && s_q.cmd.size == lsse_pkg::LSSE_SZ_HALF && s_q.state == lsse_pkg::LSSE_ST_SINGLE
		|-> o_mem.be == (o_mem.addr[1] ? `LSSE_BE_HALF_HI : `LSSE_BE_HALF_LO))
		else $error("peripheral halfword lane wrong");
	chk_single_addr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		idle && i_cmd_valid && i_cmd.op == lsse_pkg::LSSE_OP_LOAD_REGISTER && i_cmd.base_register != `LSSE_PROG_IDX
		|=> o_mem.req && o_mem.addr == $past(s_q.regs[i_cmd.base_register]) +
			($past(s_q.regs[i_cmd.offset_register]) << $past(i_cmd.left_shift_option)))
		else $error("effective address wrong");
	chk_word_enable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_mem.req && s_q.state == lsse_pkg::LSSE_ST_SINGLE && s_q.cmd.size == lsse_pkg::LSSE_SZ_WORD
		|-> o_mem.be == `LSSE_BE_WORD)
		else $error("word access not full width");
	chk_zero_extend: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_q.state == lsse_pkg::LSSE_ST_SINGLE && i_mem_ack && !s_q.mem.we && !s_q.cmd.sign &&
		s_q.cmd.size == lsse_pkg::LSSE_SZ_BYTE
		|=> s_q.regs[$past(s_q.cmd.transfer_register)][31:8] == 24'h0)
		else $error("unsigned byte not zero-extended");
	chk_signed_store: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		idle && i_cmd_valid && i_cmd.op == lsse_pkg::LSSE_OP_STORE_REGISTER && i_cmd.sign
		|=> o_fault && o_done && !o_mem.req)
		else $error("signed store not refused");
	chk_push_start: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		idle && i_cmd_valid && i_cmd.op == lsse_pkg::LSSE_OP_STORE_MULTIPLE_DECREMENT_BEFORE &&
		i_cmd.reg_list == 16'h00F1
		|=> o_mem.addr == $past(s_q.regs[`LSSE_STACK_IDX]) - 32'h14)
		else $error("stack store start address wrong");
	chk_beat_order: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_q.state == lsse_pkg::LSSE_ST_MULTI && i_mem_ack && (s_q.list & (s_q.list - 16'h1)) != 16'h0
		|=> o_mem.addr == $past(o_mem.addr) + `LSSE_WORD_STEP && o_mem.req)
		else $error("stack beats not ascending");
	chk_pop_fill: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_q.state == lsse_pkg::LSSE_ST_MULTI && i_mem_ack && !s_q.mem.we && !s_q.list[0] && s_q.list[1]
		|=> s_q.regs[1] == $past(i_mem_rdata))
		else $error("stack load filled wrong register");
	chk_branch_align: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_branch |-> s_q.regs[`LSSE_PROG_IDX] == ($past(i_mem_rdata) & `LSSE_BRANCH_MASK) &&
			o_fault == !$past(i_mem_rdata[0]))
		else $error("branch target not halfword aligned");
	chk_flags_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!idle |=> $stable(o_flags))
		else $error("flags changed during transfer");

	// main scenarios
	cov_single_load: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		s_q.state == lsse_pkg::LSSE_ST_SINGLE && i_mem_ack && !s_q.mem.we);
	cov_push_done: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		s_q.state == lsse_pkg::LSSE_ST_MULTI && s_q.mem.we ##1 o_done);
	cov_pop_branch: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_branch);
	cov_refused: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_fault && idle);
endmodule

// *** verilog/lsse_lane.sv ***
// Purpose: little-endian byte lane steering and load extension
// Assumes: halfwords use address bit 1, bytes bits 1:0
// Notes: one lane order for every region and size
`timescale 1ns/1ns
`include "lsse_params.svh"
module lsse_lane
(
	// access shape
	input wire logic [1:0] i_addr_lo,
	input wire lsse_pkg::lsse_size_t i_size,
	input wire logic i_sign,
	// data
	input wire logic [31:0] i_store_data,
	input wire logic [31:0] i_load_data,
	output logic [31:0] o_wdata,
	output logic [3:0] o_be,
	output logic [31:0] o_value
);
	logic [7:0] byte_v;
	logic [15:0] half_v;
	// lane 0 holds the lowest address
	always_comb
	begin
		byte_v = 8'h00;
		half_v = 16'h0000;
		case (i_addr_lo)
			2'h0: byte_v = i_load_data[7:0];
			2'h1: byte_v = i_load_data[15:8];
			2'h2: byte_v = i_load_data[23:16];
			default: byte_v = i_load_data[31:24];
		endcase
		half_v = i_addr_lo[1] ? i_load_data[31:16] : i_load_data[15:0];
		case (i_size)
			lsse_pkg::LSSE_SZ_BYTE:
			begin
				o_wdata = {4{i_store_data[7:0]}};
				o_be = `LSSE_BE_BYTE0 << i_addr_lo;
				o_value = i_sign ? {{24{byte_v[7]}}, byte_v} : {24'h0, byte_v};
			end
			lsse_pkg::LSSE_SZ_HALF:
			begin
				o_wdata = {2{i_store_data[15:0]}};
				o_be = i_addr_lo[1] ? `LSSE_BE_HALF_HI : `LSSE_BE_HALF_LO;
				o_value = i_sign ? {{16{half_v[15]}}, half_v} : {16'h0, half_v};
			end
			default:
			begin
				o_wdata = i_store_data;
				o_be = `LSSE_BE_WORD;
				o_value = i_load_data;
			end
		endcase
	end
endmodule

// *** verilog/lsse_params.svh ***
// Purpose: constants of the load/store and stack execution block
// Assumes: 32-bit data, sixteen core registers
// Notes: included by bare name
`ifndef LSSE_PARAMS_SVH
`define LSSE_PARAMS_SVH
`define LSSE_STACK_IDX 4'hD
`define LSSE_LINK_IDX 4'hE
`define LSSE_PROG_IDX 4'hF
`define LSSE_MAX_SHIFT 2'h3
`define LSSE_WORD_STEP 32'h4
`define LSSE_RST_WORD 32'h0
`define LSSE_RST_FLAGS 4'h0
`define LSSE_BRANCH_MASK 32'hFFFFFFFE
`define LSSE_PERIPH_LO 32'hE0000000
`define LSSE_PERIPH_HI 32'hE00FFFFF
`define LSSE_BE_WORD 4'hF
`define LSSE_BE_BYTE0 4'h1
`define LSSE_BE_HALF_LO 4'h3
`define LSSE_BE_HALF_HI 4'hC
`endif

// *** verilog/lsse_pkg.sv ***
// Purpose: types shared by the load/store and stack execution block
// Assumes: commands arrive already decoded
// Notes: no constants here, see lsse_params.svh
package lsse_pkg;
	typedef enum logic [1:0] {
		LSSE_OP_LOAD_REGISTER,
		LSSE_OP_STORE_REGISTER,
		LSSE_OP_STORE_MULTIPLE_DECREMENT_BEFORE,
		LSSE_OP_LOAD_MULTIPLE_INCREMENT_AFTER
	} lsse_op_t;
	// word is the first code so that an omitted size means word
	typedef enum logic [1:0] {
		LSSE_SZ_WORD,
		LSSE_SZ_BYTE,
		LSSE_SZ_HALF
	} lsse_size_t;
	typedef enum logic [1:0] {
		LSSE_ST_IDLE,
		LSSE_ST_SINGLE,
		LSSE_ST_MULTI
	} lsse_state_t;
	typedef struct packed {
		lsse_op_t op;
		lsse_size_t size;
		logic sign;
		logic [3:0] transfer_register;
		logic [3:0] base_register;
		logic [3:0] offset_register;
		logic [1:0] left_shift_option;
		logic [15:0] reg_list;
	} lsse_cmd_t;
	typedef struct packed {
		logic req;
		logic we;
		logic periph;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0] be;
	} lsse_mem_t;
	typedef struct packed {
		lsse_state_t state;
		lsse_cmd_t cmd;
		logic [15:0] list;
		logic [31:0] stack_new;
		logic [15:0][31:0] regs;
		logic [3:0] flags;
		lsse_mem_t mem;
		logic busy;
		logic done;
		logic fault;
		logic branch;
		logic [31:0] dbg_data;
	} lsse_exec_state_t;
endpackage
